// ===== strap_step_pkg.sv
/*
 * Shared constants and types for the strap and oscillator step control block.
 * Assumes a 40 MHz system clock and 32-bit APB register access.
 */
package strap_step_pkg;

    localparam int ADDR_W = 12;
    localparam int NUM_W = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STEP_SIZE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_LOOP1_NUM = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_LOOP2_NUM = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_STEP_CMD = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_STATUS_PIN = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_ADDR = 12'h018;

    // Control register fields.
    localparam int CTRL_LOOP1_NCO = 0;
    localparam int CTRL_LOOP2_NCO = 1;
    localparam int CTRL_UPPER_LSB = 8;
    localparam int CTRL_UPPER_W = 5;

    // Step command fields (write one to request a step).
    localparam int CMD_UP = 0;
    localparam int CMD_DOWN = 1;

    // Status pin configuration fields.
    localparam int SP_UP_STATUS = 0;
    localparam int SP_DOWN_STATUS = 1;
    localparam int SP_UP_PUSHPULL = 2;
    localparam int SP_DOWN_PUSHPULL = 3;
    localparam int SP_UP_VALUE = 4;
    localparam int SP_DOWN_VALUE = 5;

    // Reset values.
    localparam logic [4:0] UPPER_ADDR_RESET = 5'h18;
    localparam logic [NUM_W-1:0] STEP_SIZE_RESET = 32'h0000_0001;
    localparam logic [NUM_W-1:0] NUM_RESET = 32'h0000_0000;

    // Cycles after reset release before the straps are latched.
    localparam int STRAP_SETTLE = 4;

    typedef enum logic [1:0] {STEP_NONE, STEP_UP, STEP_DOWN} step_t;

endpackage

// ===== strap_step_ctrl.sv
/*
 * Strap-derived target address and oscillator numerator stepping by pins, or by registers for loop one only.
 * Assumes pins are asynchronous to clk and an APB master on the register side.
 */
`timescale 1ns/1ps
`default_nettype none
module strap_step_ctrl
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [strap_step_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] addrStrapPin,
    input wire logic loop1_freq_up_pin,
    input wire logic loop1_freq_down_pin,
    input wire logic loop2_freq_up_pin_i,
    output logic loop2_freq_up_pin_o,
    output logic loop2_freq_up_pin_oe,
    input wire logic loop2_freq_down_pin_i,
    output logic loop2_freq_down_pin_o,
    output logic loop2_freq_down_pin_oe,
    output logic [6:0] targetAddress,
    output logic [strap_step_pkg::NUM_W-1:0] loop1Numerator,
    output logic [strap_step_pkg::NUM_W-1:0] loop2Numerator
);
    import strap_step_pkg::*;

    typedef struct packed {
        logic [2:0][5:0] sync;
        logic [3:0] prevLevel;
        logic [2:0] settle;
        logic strapDone;
        logic [6:0] targetAddress;
        logic loop1Nco;
        logic loop2Nco;
        logic [4:0] upperAddr;
        logic [NUM_W-1:0] stepSize;
        logic [5:0] statusPin;
        logic [NUM_W-1:0] num1;
        logic [NUM_W-1:0] num2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic upO;
        logic upOe;
        logic downO;
        logic downOe;
    } state_t;

    state_t r;
    state_t next_r;

    ////////////////////////////////////////////////////////////////////////////
    // Applies one step to a numerator.
    function automatic logic [NUM_W-1:0] applyStep(input logic [NUM_W-1:0] num,
        input logic [NUM_W-1:0] size, input step_t dir);
        applyStep = num;
        case (dir)
            STEP_UP: applyStep = num + size;
            STEP_DOWN: applyStep = num - size;
            default: applyStep = num;
        endcase
    endfunction

    // Picks the step direction; simultaneous up and down cancel.
    function automatic step_t stepDir(input logic up, input logic down);
        stepDir = STEP_NONE;
        if (up && !down)
        begin
            stepDir = STEP_UP;
        end
        else if (down && !up)
        begin
            stepDir = STEP_DOWN;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [5:0] pins;
        logic [3:0] level;
        logic [3:0] rise;
        logic wr;
        logic rd;
        logic regUp;
        logic regDown;
        pins = '0;
        level = '0;
        rise = '0;
        wr = 1'b0;
        rd = 1'b0;
        regUp = 1'b0;
        regDown = 1'b0;
        next_r = r;
        pins = {loop2_freq_down_pin_i, loop2_freq_up_pin_i, loop1_freq_down_pin,
            loop1_freq_up_pin, addrStrapPin};
        next_r.sync[0] = pins;
        next_r.sync[1] = r.sync[0];
        next_r.sync[2] = r.sync[1];
        // A level counts once the second and third stages agree.
        for (int i = 0; i < 4; i++)
        begin
            level[i] = (r.sync[1][i+2] == r.sync[2][i+2]) ? r.sync[2][i+2] : r.prevLevel[i];
        end
        rise = level & ~r.prevLevel;
        next_r.prevLevel = level;

        // Straps are latched once a short settle after reset release.
        if (!r.strapDone)
        begin
            if (r.settle == 3'(STRAP_SETTLE - 1))
            begin
                next_r.strapDone = 1'b1;
                next_r.targetAddress = {r.upperAddr, r.sync[2][1:0]};
            end
            else
            begin
                next_r.settle = r.settle + 3'h1;
            end
        end

        // APB slave with zero wait states.
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        wr = psel && !penable && pwrite;
        rd = psel && !penable && !pwrite;
        if (psel && !penable)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
        end
        if (wr)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    next_r.loop1Nco = pwdata[CTRL_LOOP1_NCO];
                    next_r.loop2Nco = pwdata[CTRL_LOOP2_NCO];
                    next_r.upperAddr = pwdata[CTRL_UPPER_LSB +: CTRL_UPPER_W];
                end
                OFS_STEP_SIZE: next_r.stepSize = pwdata;
                OFS_STEP_CMD:
                begin
                    regUp = pwdata[CMD_UP];
                    regDown = pwdata[CMD_DOWN];
                end
                OFS_STATUS_PIN: next_r.statusPin = pwdata[5:0];
                OFS_LOOP1_NUM, OFS_LOOP2_NUM, OFS_ADDR:
                begin
                    next_r.pslverr = 1'b1;
                end
                default: next_r.pslverr = 1'b1;
            endcase
        end
        if (rd)
        begin
            case (paddr)
                OFS_CTRL: next_r.prdata = {19'h0, r.upperAddr, 6'h0, r.loop2Nco, r.loop1Nco};
                OFS_STEP_SIZE: next_r.prdata = r.stepSize;
                OFS_LOOP1_NUM: next_r.prdata = r.num1;
                OFS_LOOP2_NUM: next_r.prdata = r.num2;
                OFS_STEP_CMD: next_r.prdata = 32'h0000_0000;
                OFS_STATUS_PIN: next_r.prdata = {26'h0, r.statusPin};
                OFS_ADDR: next_r.prdata = {24'h0, r.strapDone, r.targetAddress};
                default: next_r.pslverr = 1'b1;
            endcase
        end

        // Loop one steps from pin edges or register requests.
        if (r.loop1Nco)
        begin
            next_r.num1 = applyStep(r.num1, r.stepSize,
                stepDir(rise[0] || regUp, rise[1] || regDown));
        end
        // Loop two pins step only while they are not status outputs.
        if (r.loop2Nco)
        begin
            next_r.num2 = applyStep(r.num2, r.stepSize,
                stepDir(rise[2] && !r.statusPin[SP_UP_STATUS],
                rise[3] && !r.statusPin[SP_DOWN_STATUS]));
        end

        // Status drivers: push-pull drives both levels, open-drain only pulls low.
        next_r.upO = r.statusPin[SP_UP_VALUE];
        next_r.upOe = r.statusPin[SP_UP_STATUS] && (r.statusPin[SP_UP_PUSHPULL]
            || !r.statusPin[SP_UP_VALUE]);
        next_r.downO = r.statusPin[SP_DOWN_VALUE];
        next_r.downOe = r.statusPin[SP_DOWN_STATUS] && (r.statusPin[SP_DOWN_PUSHPULL]
            || !r.statusPin[SP_DOWN_VALUE]);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
            r.upperAddr <= UPPER_ADDR_RESET;
            r.targetAddress <= {UPPER_ADDR_RESET, 2'b00};
            r.stepSize <= STEP_SIZE_RESET;
            r.num1 <= NUM_RESET;
            r.num2 <= NUM_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign targetAddress = r.targetAddress;
    assign loop1Numerator = r.num1;
    assign loop2Numerator = r.num2;
    assign loop2_freq_up_pin_o = r.upO;
    assign loop2_freq_up_pin_oe = r.upOe;
    assign loop2_freq_down_pin_o = r.downO;
    assign loop2_freq_down_pin_oe = r.downOe;

endmodule
`default_nettype wire

// ===== strap_step_sva.sv
/* Port assertions for the strap and step block.
   Bound to every strap_step_ctrl instance. */
`timescale 1ns/1ps
`default_nettype none
module strap_step_sva
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic loop1_freq_up_pin,
    input wire logic loop1_freq_down_pin,
    input wire logic loop2_freq_up_pin_i,
    input wire logic loop2_freq_down_pin_i,
    input wire logic [6:0] targetAddress,
    input wire logic [31:0] loop1Numerator,
    input wire logic [31:0] loop2Numerator
);
    import strap_step_pkg::*;
    logic [3:0] age;
    logic [3:0] quiet1;
    logic [3:0] quiet2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            age <= 4'hF;
            quiet1 <= 4'hF;
            quiet2 <= 4'hF;
        end
        else
        begin
            age <= (age == 4'hF) ? 4'h0 : ((age == 4'hE) ? age : age + 4'h1);
            quiet1 <= (psel | loop1_freq_up_pin | loop1_freq_down_pin) ? 4'h0
                : ((quiet1 == 4'hF) ? quiet1 : quiet1 + 4'h1);
            quiet2 <= (loop2_freq_up_pin_i | loop2_freq_down_pin_i) ? 4'h0
                : ((quiet2 == 4'hF) ? quiet2 : quiet2 + 4'h1);
        end
    end
    sequence setup;
        psel && !penable;
    endsequence
    AST_ADDR_UPPER: assert property (targetAddress[6:2] == UPPER_ADDR_RESET)
        else $error("upper address bits wrong");
    AST_ADDR_HOLD: assert property (age == 4'hE |-> $stable(targetAddress))
        else $error("target address moved after start-up");
    AST_APB_ANSWER: assert property (setup |=> pready)
        else $error("no ready one cycle after setup");
    AST_APB_READY_PHASE: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_L1_CAUSE: assert property ($changed(loop1Numerator) |-> quiet1 < 4'h8)
        else $error("loop one numerator moved without a request");
    AST_L1_ONE_STEP: assert property ($changed(loop1Numerator) |=> $stable(loop1Numerator))
        else $error("loop one numerator stepped twice");
    AST_L2_CAUSE: assert property ($changed(loop2Numerator) |-> quiet2 < 4'h8)
        else $error("loop two numerator moved without a request");
endmodule
bind strap_step_ctrl strap_step_sva chk (.clk, .nrst, .psel, .penable, .pready, .pslverr,
    .loop1_freq_up_pin, .loop1_freq_down_pin, .loop2_freq_up_pin_i, .loop2_freq_down_pin_i,
    .targetAddress, .loop1Numerator, .loop2Numerator);
`default_nettype wire

// ===== board_pins.sv
/* Board side model: strap resistors and a controller pulsing step pins.
   Pins are pulled low unless driven; status drivers win when enabled. */
`timescale 1ns/1ps
`default_nettype none
module board_pins
(
    input wire logic clk,
    input wire logic upO,
    input wire logic upOe,
    input wire logic downO,
    input wire logic downOe,
    output logic [1:0] addrStrapPin,
    output logic loop1_freq_up_pin,
    output logic loop1_freq_down_pin,
    output logic loop2UpLevel,
    output logic loop2DownLevel
);
    logic [3:0] drive;
    logic [1:0] strap;
    initial
    begin
        drive <= 4'h0;
        strap <= 2'b10;
    end
    assign addrStrapPin = strap;
    assign loop1_freq_up_pin = drive[0];
    assign loop1_freq_down_pin = drive[1];
    assign loop2UpLevel = upOe ? upO : drive[2];
    assign loop2DownLevel = downOe ? downO : drive[3];
    task automatic set_strap(input logic [1:0] s);
        strap <= s;
    endtask
    task automatic pulse(input int p);
        drive[p] <= 1'b1;
        repeat (4) @(posedge clk);
        drive[p] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== strap_step_ctrl_test.sv
/* Self-checking bench for strap_step_ctrl.
   Uses board_pins as the board and an APB master task. */
`timescale 1ns/1ps
`default_nettype none
module strap_step_ctrl_test;
    import strap_step_pkg::*;
    logic clk;
    logic nrst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata, rd, num1, num2;
    logic pready, pslverr, err, up1, down1, up2, down2, upO, upOe, downO, downOe;
    logic [1:0] strapPin;
    logic [6:0] targetAddress;
    int fails = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    strap_step_ctrl uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .addrStrapPin(strapPin), .loop1_freq_up_pin(up1),
        .loop1_freq_down_pin(down1), .loop2_freq_up_pin_i(up2), .loop2_freq_up_pin_o(upO),
        .loop2_freq_up_pin_oe(upOe), .loop2_freq_down_pin_i(down2),
        .loop2_freq_down_pin_o(downO), .loop2_freq_down_pin_oe(downOe), .targetAddress,
        .loop1Numerator(num1), .loop2Numerator(num2));
    board_pins pins (.clk, .upO, .upOe, .downO, .downOe, .addrStrapPin(strapPin),
        .loop1_freq_up_pin(up1), .loop1_freq_down_pin(down1), .loop2UpLevel(up2),
        .loop2DownLevel(down2));
    task automatic wrap_up();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
        begin
            fails++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        chk("address", 32'h0000_0062, 32'(targetAddress));
        pins.set_strap(2'b01);
        apb(1'b0, OFS_ADDR, 32'h0);
        chk("address reg", 32'h0000_00E2, rd);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("control", 32'h0000_1800, rd);
        apb(1'b1, OFS_STEP_SIZE, 32'h0000_0005);
        pins.pulse(0);
        chk("mode off", 32'h0, num1);
        apb(1'b1, OFS_CTRL, 32'h0000_1803);
        pins.pulse(0);
        chk("pin up", 32'h0000_0005, num1);
        pins.pulse(1);
        pins.pulse(1);
        chk("pin down", 32'hFFFF_FFFB, num1);
        apb(1'b1, OFS_STEP_CMD, 32'h0000_0001);
        chk("reg up", 32'h0, num1);
        apb(1'b1, OFS_STEP_CMD, 32'h0000_0002);
        chk("reg down", 32'hFFFF_FFFB, num1);
        apb(1'b1, OFS_LOOP1_NUM, 32'h0);
        chk("read-only", 32'h1, 32'(err));
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        pins.pulse(2);
        chk("loop2 up", 32'h0000_0005, num2);
        pins.pulse(3);
        chk("loop2 down", 32'h0, num2);
        apb(1'b1, OFS_STATUS_PIN, 32'h0000_003F);
        chk("push-pull", 32'hF, 32'({upOe, upO, downOe, downO}));
        apb(1'b1, OFS_STATUS_PIN, 32'h0000_0013);
        chk("open-drain", 32'h2, 32'({upOe, downOe, downO}));
        pins.pulse(2);
        chk("status pin", 32'h0, num2);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset address", 32'h0000_0060, 32'(targetAddress));
        chk("reset numerator", 32'h0, num1);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        chk("restart address", 32'h0000_0061, 32'(targetAddress));
        wrap_up();
    end
endmodule
`default_nettype wire
